// file: core/chp_params.svh
// Constants for the card host port: widths, pin idle levels and reset values.
// Assumes it is included by bare name from the package and the design modules.
// Contract
// (RULE1) Input acknowledge only on selected I/O reads
// (RULE2) Host gates its data buffers with acknowledge
// (RULE3) Memory mode ignores read strobe and acknowledge
// (RULE4) Raise DMA request when ready to move data
// (RULE5) Pulsed strobe sets multiword DMA direction
// (RULE6) Hold DMA request until acknowledge arrives
// (RULE7) Request again while more data remains
// (RULE8) Float DMA request when not selected
// (RULE9) DMA needs chip selects negated, 16-bit words
// (RULE10) Drive read data while read strobe asserted
// (RULE11) Direct disk reads act as I/O reads
// (RULE12) Host asserts ready during Ultra DMA reads
// (RULE13) Host ready negated pauses data-in words
// (RULE14) Host strobes write data on read pin
// (RULE15) Latch word on both host strobe edges
// (RULE16) No strobe edges means nothing latched
// (RULE17) Ignore DMA acknowledge while DMA inactive
// (RULE18) Stop on write pin ends Ultra burst
// (RULE19) Host grounds mode select for direct disk
// (RULE20) Drop acknowledge once strobe or select negates
// (RULE21) Synchronise strobe edges before buffering words
`ifndef CHP_PARAMS_SVH
`define CHP_PARAMS_SVH

// ----------------------------------------------------------------
// Widths
// ----------------------------------------------------------------
`define CHP_DATA_W     16
`define CHP_PIN_N      8
`define CHP_CTL_N      6
`define CHP_STRAP_W    2

// ----------------------------------------------------------------
// Reset and idle values
// ----------------------------------------------------------------
`define CHP_PIN_IDLE   8'hBF
`define CHP_RST_WORD   16'h0000
`define CHP_RST_CTL    6'h00
`define CHP_STRAP_DONE 2'h3

`endif

// file: core/chp_pkg.sv
// Types shared by the card host port modules.
// Assumes chp_params.svh is on the include path.
`include "chp_params.svh"

package chp_pkg;

  // ----------------------------------------------------------------
  // DMA request handshake states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    dq_idle,
    dq_req,
    dq_ack
  } chp_dq_state_t;

  typedef logic [`CHP_DATA_W-1:0] chp_word_t;

endpackage : chp_pkg

// file: core/chp_xfer_if.sv
// Word crossing carrier between the port logic and the crossing module.
// Assumes source and sink sides live in different clock domains.
`timescale 1ns/1ps

interface chp_xfer_if #(
  parameter int W = 16
);
  logic         src_valid;
  logic         src_ready;
  logic [W-1:0] src_data;
  logic         dst_ready;
  logic         dst_valid;
  logic [W-1:0] dst_data;

  modport src  (output src_valid, output src_data, input src_ready);
  modport dst  (output dst_ready, input dst_valid, input dst_data);
  modport xfer (input src_valid, input src_data, input dst_ready,
                output src_ready, output dst_valid, output dst_data);
endinterface : chp_xfer_if

// file: core/chp_word_xfer.sv
// Toggle handshake that carries one word at a time between two clock domains.
// Assumes each side holds a synchronous active-low reset of its own domain.
`timescale 1ns/1ps

module chp_word_xfer #(
  parameter int W = 16
) (
  input  wire logic src_clk,
  input  wire logic src_rst_b,
  input  wire logic dst_clk,
  input  wire logic dst_rst_b,
  chp_xfer_if.xfer  x
);
  logic         req_tgl_r;
  logic         ack_meta_r;
  logic         ack_sync_r;
  logic [W-1:0] hold_r;
  logic         req_meta_r;
  logic         req_sync_r;
  logic         ack_tgl_r;
  logic         valid_r;
  logic [W-1:0] data_r;
  logic         take;

  // ----------------------------------------------------------------
  // Source side: word held stable until the acknowledge returns
  // ----------------------------------------------------------------
  assign x.src_ready = (req_tgl_r == ack_sync_r);

  always_ff @(posedge src_clk)
  begin
    if (!src_rst_b)
    begin
      req_tgl_r <= 1'b0;
      hold_r    <= '0;
    end
    else if (x.src_valid && x.src_ready)
    begin
      req_tgl_r <= ~req_tgl_r;
      hold_r    <= x.src_data;
    end
  end

  always_ff @(posedge src_clk)
  begin
    if (!src_rst_b)
    begin
      ack_meta_r <= 1'b0;
      ack_sync_r <= 1'b0;
    end
    else
    begin
      ack_meta_r <= ack_tgl_r;
      ack_sync_r <= ack_meta_r;
    end
  end

  // ----------------------------------------------------------------
  // Sink side: takes the word only when the consumer has room
  // ----------------------------------------------------------------
  assign take = (req_sync_r != ack_tgl_r) && x.dst_ready;

  always_ff @(posedge dst_clk)
  begin
    if (!dst_rst_b)
    begin
      req_meta_r <= 1'b0;
      req_sync_r <= 1'b0;
    end
    else
    begin
      req_meta_r <= req_tgl_r;
      req_sync_r <= req_meta_r;
    end
  end

  always_ff @(posedge dst_clk)
  begin
    if (!dst_rst_b)
    begin
      ack_tgl_r <= 1'b0;
      valid_r   <= 1'b0;
      data_r    <= '0;
    end
    else
    begin
      valid_r <= take;
      if (take)
      begin
        ack_tgl_r <= ~ack_tgl_r;
        data_r    <= hold_r;
      end
    end
  end

  assign x.dst_valid = valid_r;
  assign x.dst_data  = data_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_hold_stable;
    @(posedge src_clk) disable iff (!src_rst_b)
      !x.src_ready |=> $stable(hold_r);
  endproperty
  a_hold_stable: assert property (p_hold_stable) else $error("crossing word changed while in flight"); // RULE21

  property p_valid_pulse;
    @(posedge dst_clk) disable iff (!dst_rst_b)
      valid_r |=> !valid_r;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("crossing delivered two words back to back"); // RULE21

endmodule : chp_word_xfer

// file: core/chp_host_port.sv
// Card-side host bus port: input acknowledge, read strobe, DMA handshake, Ultra DMA strobes.
// Assumes pins arrive asynchronously to link_clk; core side logic runs on core_clk.
`timescale 1ns/1ps
`include "chp_params.svh"

module chp_host_port
  import chp_pkg::*;
#(
  parameter int DATA_W = `CHP_DATA_W
) (
  input  wire logic              core_clk,
  input  wire logic              rst_b,
  input  wire logic              link_clk,
  // Host pins
  input  wire logic              card_select_n,
  input  wire logic              io_addr_hit,
  input  wire logic              chip_select_0_n,
  input  wire logic              chip_select_1_n,
  input  wire logic              disk_mode_select_n,
  input  wire logic              io_read_strobe_n,
  input  wire logic              io_write_strobe_n,
  input  wire logic              dma_acknowledge_n,
  input  wire logic [DATA_W-1:0] data_in,
  output logic      [DATA_W-1:0] data_out,
  output logic                   data_oe,
  output logic                   input_ack_n,
  output logic                   dma_request,
  output logic                   dma_request_oe,
  output logic                   device_data_strobe,
  // Core side
  input  wire logic              cfg_io_mode,
  input  wire logic              dev_selected,
  input  wire logic              dma_active,
  input  wire logic              udma_active,
  input  wire logic              dir_write,
  input  wire logic              xfer_ready,
  input  wire logic [DATA_W-1:0] rd_word,
  input  wire logic              rd_valid,
  output logic                   rd_ready,
  output logic      [DATA_W-1:0] wr_word,
  output logic                   wr_valid,
  output logic                   burst_stopped,
  output logic                   direct_disk_mode
);
  localparam int P_SEL  = 7;
  localparam int P_HIT  = 6;
  localparam int P_CS0  = 5;
  localparam int P_CS1  = 4;
  localparam int P_MODE = 3;
  localparam int P_RD   = 2;
  localparam int P_WR   = 1;
  localparam int P_ACK  = 0;

  // ----------------------------------------------------------------
  // Crossing carriers
  // ----------------------------------------------------------------
  chp_xfer_if #(.W(DATA_W)) rd_if ();
  chp_xfer_if #(.W(DATA_W)) wr_if ();

  logic lrst_meta_r;
  logic lrst_b_r;

  chp_word_xfer #(.W(DATA_W)) u_rd_xfer (
    .src_clk   (core_clk),
    .src_rst_b (rst_b),
    .dst_clk   (link_clk),
    .dst_rst_b (lrst_b_r),
    .x         (rd_if.xfer)
  );

  chp_word_xfer #(.W(DATA_W)) u_wr_xfer (
    .src_clk   (link_clk),
    .src_rst_b (lrst_b_r),
    .dst_clk   (core_clk),
    .dst_rst_b (rst_b),
    .x         (wr_if.xfer)
  );

  // ----------------------------------------------------------------
  // Core domain: control levels, word paths, event returns
  // ----------------------------------------------------------------
  logic [`CHP_CTL_N-1:0] ctl_r;
  logic                  dd_meta_c_r;
  logic                  dd_sync_c_r;
  logic                  stp_meta_r;
  logic                  stp_sync_r;
  logic                  stp_prev_r;
  logic                  burst_stopped_r;
  logic                  dd_mode_r;
  logic                  stop_tgl_r;

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
      ctl_r <= `CHP_RST_CTL;
    else
      ctl_r <= {cfg_io_mode, dev_selected, dma_active, udma_active, dir_write, xfer_ready};
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      dd_meta_c_r     <= 1'b0;
      dd_sync_c_r     <= 1'b0;
      stp_meta_r      <= 1'b0;
      stp_sync_r      <= 1'b0;
      stp_prev_r      <= 1'b0;
      burst_stopped_r <= 1'b0;
    end
    else
    begin
      dd_meta_c_r     <= dd_mode_r;
      dd_sync_c_r     <= dd_meta_c_r;
      stp_meta_r      <= stop_tgl_r;
      stp_sync_r      <= stp_meta_r;
      stp_prev_r      <= stp_sync_r;
      burst_stopped_r <= stp_sync_r ^ stp_prev_r;
    end
  end

  assign rd_if.src_valid  = rd_valid;
  assign rd_if.src_data   = rd_word;
  assign rd_ready         = rd_if.src_ready;
  assign wr_if.dst_ready  = 1'b1;
  assign wr_word          = wr_if.dst_data;
  assign wr_valid         = wr_if.dst_valid;
  assign burst_stopped    = burst_stopped_r;
  assign direct_disk_mode = dd_sync_c_r;

  // ----------------------------------------------------------------
  // Link domain: reset, pin and control synchronisers, mode strap
  // ----------------------------------------------------------------
  logic [`CHP_PIN_N-1:0] pin_meta_r;
  logic [`CHP_PIN_N-1:0] pin_sync_r;
  logic [`CHP_PIN_N-1:0] pin_prev_r;
  logic [DATA_W-1:0]     dat_meta_r;
  logic [DATA_W-1:0]     dat_sync_r;
  logic [`CHP_CTL_N-1:0] ctl_meta_r;
  logic [`CHP_CTL_N-1:0] ctl_sync_r;
  logic [`CHP_STRAP_W-1:0] strap_cnt_r;

  always_ff @(posedge link_clk)
  begin
    lrst_meta_r <= rst_b;
    lrst_b_r    <= lrst_meta_r;
  end

  always_ff @(posedge link_clk)
  begin
    if (!lrst_b_r)
    begin
      pin_meta_r <= `CHP_PIN_IDLE;
      pin_sync_r <= `CHP_PIN_IDLE;
      pin_prev_r <= `CHP_PIN_IDLE;
      dat_meta_r <= `CHP_RST_WORD;
      dat_sync_r <= `CHP_RST_WORD;
      ctl_meta_r <= `CHP_RST_CTL;
      ctl_sync_r <= `CHP_RST_CTL;
    end
    else
    begin
      pin_meta_r <= {card_select_n, io_addr_hit, chip_select_0_n, chip_select_1_n,
                     disk_mode_select_n, io_read_strobe_n, io_write_strobe_n, dma_acknowledge_n};
      pin_sync_r <= pin_meta_r;
      pin_prev_r <= pin_sync_r;
      dat_meta_r <= data_in;
      dat_sync_r <= dat_meta_r;
      ctl_meta_r <= ctl_r;
      ctl_sync_r <= ctl_meta_r;
    end
  end

  // Mode strap caught once the synchronisers hold real pin levels
  always_ff @(posedge link_clk)
  begin
    if (!lrst_b_r)
    begin
      strap_cnt_r <= '0;
      dd_mode_r   <= 1'b0;
    end
    else if (strap_cnt_r != `CHP_STRAP_DONE)
    begin
      strap_cnt_r <= strap_cnt_r + 1'b1;
      dd_mode_r   <= ~pin_sync_r[P_MODE]; // RULE19
    end
  end

  // ----------------------------------------------------------------
  // Link domain: decoded conditions
  // ----------------------------------------------------------------
  logic io_mode_w;
  logic mem_mode_w;
  logic sel_w;
  logic dev_sel_w;
  logic dma_on_w;
  logic udma_on_w;
  logic dwr_w;
  logic io_read_strobe_n_act_w;
  logic io_read_strobe_n_rise_w;
  logic io_write_strobe_n_rise_w;
  logic dma_ack_q;
  logic cs_clear_w;
  logic io_read_sel;
  logic dd_pio_read;
  logic mdma_ok;
  logic mdma_read;
  logic hstb_edge;
  logic stop_evt;
  logic stop_r;
  logic rd_have_r;
  logic udma_rd_ctx;
  logic udma_send;
  logic consume;
  logic start_ok;

  assign io_mode_w   = !dd_mode_r && ctl_sync_r[5];
  assign mem_mode_w  = !dd_mode_r && !ctl_sync_r[5];
  assign sel_w       = !pin_sync_r[P_SEL] && pin_sync_r[P_HIT];
  assign dev_sel_w   = ctl_sync_r[4];
  assign dma_on_w    = dd_mode_r && ctl_sync_r[3];
  assign udma_on_w   = dma_on_w && ctl_sync_r[2];
  assign dwr_w       = ctl_sync_r[1];
  assign io_read_strobe_n_act_w  = !pin_sync_r[P_RD];
  assign io_read_strobe_n_rise_w = pin_sync_r[P_RD] && !pin_prev_r[P_RD];
  assign io_write_strobe_n_rise_w = pin_sync_r[P_WR] && !pin_prev_r[P_WR];
  assign cs_clear_w  = pin_sync_r[P_CS0] && pin_sync_r[P_CS1];

  assign dma_ack_q   = dma_on_w && !pin_sync_r[P_ACK]; // RULE17
  assign io_read_sel = io_mode_w && sel_w && io_read_strobe_n_act_w; // RULE1 RULE3
  assign dd_pio_read = dd_mode_r && !dma_ack_q && !cs_clear_w && io_read_strobe_n_act_w; // RULE11
  assign mdma_ok     = dma_ack_q && cs_clear_w && !udma_on_w; // RULE9
  assign mdma_read   = mdma_ok && io_read_strobe_n_act_w; // RULE5

  // Either host strobe edge marks a word; pause simply yields no edge
  assign hstb_edge   = udma_on_w && dwr_w && dma_ack_q && cs_clear_w && !stop_r &&
                       (pin_sync_r[P_RD] ^ pin_prev_r[P_RD]); // RULE15 RULE16 RULE21
  assign stop_evt    = udma_on_w && dma_ack_q && !stop_r && !pin_sync_r[P_WR]; // RULE18

  assign udma_rd_ctx = udma_on_w && !dwr_w && dma_ack_q && cs_clear_w && !stop_r;
  assign udma_send   = udma_rd_ctx && io_read_strobe_n_act_w && rd_have_r; // RULE12 RULE13
  assign consume     = udma_send || (rd_have_r && io_read_strobe_n_rise_w && (mdma_ok || dd_pio_read || io_mode_w));
  assign start_ok    = dma_on_w && ctl_sync_r[0] && (dwr_w ? wr_if.src_ready : rd_have_r);

  // ----------------------------------------------------------------
  // Read word holding and bus drive
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] rd_hold_r;
  logic [DATA_W-1:0] data_out_r;
  logic              data_oe_r;
  logic              dev_stb_r;
  logic              input_ack_n_r;

  assign rd_if.dst_ready = !rd_have_r || consume;

  // A word arriving in the cycle of a consume keeps the flag set
  always_ff @(posedge link_clk)
  begin
    if (!lrst_b_r)
    begin
      rd_have_r <= 1'b0;
      rd_hold_r <= `CHP_RST_WORD;
    end
    else if (rd_if.dst_valid)
    begin
      rd_have_r <= 1'b1;
      rd_hold_r <= rd_if.dst_data;
    end
    else if (consume)
      rd_have_r <= 1'b0;
  end

  always_ff @(posedge link_clk)
  begin
    if (!lrst_b_r)
    begin
      data_out_r <= `CHP_RST_WORD;
      data_oe_r  <= 1'b0;
    end
    else
    begin
      data_out_r <= rd_hold_r;
      data_oe_r  <= io_read_sel || dd_pio_read || mdma_read || udma_rd_ctx; // RULE10 RULE11
    end
  end

  always_ff @(posedge link_clk)
  begin
    if (!lrst_b_r)
      dev_stb_r <= 1'b0;
    else if (udma_send)
      dev_stb_r <= ~dev_stb_r; // RULE13
  end

  always_ff @(posedge link_clk)
  begin
    if (!lrst_b_r)
      input_ack_n_r <= 1'b1;
    else
      input_ack_n_r <= !io_read_sel; // RULE1 RULE3 RULE20
  end

  assign data_out           = data_out_r;
  assign data_oe            = data_oe_r;
  assign device_data_strobe = dev_stb_r;
  assign input_ack_n        = input_ack_n_r;

  // ----------------------------------------------------------------
  // Write word capture
  // ----------------------------------------------------------------
  // Host strobe spacing must cover the crossing round trip, else words drop
  logic              wr_cap_r;
  logic [DATA_W-1:0] wr_cap_data_r;

  always_ff @(posedge link_clk)
  begin
    if (!lrst_b_r)
    begin
      wr_cap_r      <= 1'b0;
      wr_cap_data_r <= `CHP_RST_WORD;
    end
    else
    begin
      wr_cap_r <= hstb_edge || (mdma_ok && io_write_strobe_n_rise_w); // RULE5 RULE15 RULE16
      if (hstb_edge || (mdma_ok && io_write_strobe_n_rise_w))
        wr_cap_data_r <= dat_sync_r;
    end
  end

  assign wr_if.src_valid = wr_cap_r;
  assign wr_if.src_data  = wr_cap_data_r;

  // ----------------------------------------------------------------
  // DMA request handshake
  // ----------------------------------------------------------------
  chp_dq_state_t dq_state_r;
  logic          dma_req_r;
  logic          dma_oe_r;

  always_ff @(posedge link_clk)
  begin
    if (!lrst_b_r)
      dq_state_r <= dq_idle;
    else
    begin
      unique case (dq_state_r)
        dq_idle: if (start_ok && !dma_ack_q) dq_state_r <= dq_req; // RULE4 RULE7
        dq_req:  if (dma_ack_q) dq_state_r <= dq_ack; // RULE6
        dq_ack:  if (!dma_ack_q) dq_state_r <= dq_idle;
      endcase
    end
  end

  always_ff @(posedge link_clk)
  begin
    if (!lrst_b_r)
    begin
      stop_r     <= 1'b0;
      stop_tgl_r <= 1'b0;
    end
    else if (stop_evt)
    begin
      stop_r     <= 1'b1;
      stop_tgl_r <= ~stop_tgl_r; // RULE18
    end
    else if (!dma_ack_q)
      stop_r <= 1'b0;
  end

  // Ultra bursts keep the request up until the host stops them
  always_ff @(posedge link_clk)
  begin
    if (!lrst_b_r)
    begin
      dma_req_r <= 1'b0;
      dma_oe_r  <= 1'b0;
    end
    else
    begin
      dma_req_r <= (dq_state_r == dq_idle && start_ok && !dma_ack_q) ||
                   (dq_state_r == dq_req && !dma_ack_q) ||
                   (dq_state_r != dq_idle && dma_ack_q && udma_on_w && !stop_r && !stop_evt); // RULE6 RULE18
      dma_oe_r  <= dd_mode_r && dev_sel_w; // RULE8
    end
  end

  assign dma_request    = dma_req_r;
  assign dma_request_oe = dma_oe_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_ack_cause;
    @(posedge link_clk) disable iff (!lrst_b_r)
      !input_ack_n |-> $past(io_read_sel);
  endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("input acknowledge without selected I/O read"); // RULE1

  property p_mem_no_ack;
    @(posedge link_clk) disable iff (!lrst_b_r)
      mem_mode_w && $past(mem_mode_w) |-> input_ack_n && !$past(data_oe_r && !dma_on_w);
  endproperty
  a_mem_no_ack: assert property (p_mem_no_ack) else $error("memory mode answered an I/O read"); // RULE3

  property p_ack_drop;
    @(posedge link_clk) disable iff (!lrst_b_r)
      $rose(pin_sync_r[P_RD]) |=> input_ack_n;
  endproperty
  a_ack_drop: assert property (p_ack_drop) else $error("input acknowledge outlived the read strobe"); // RULE20

  property p_req_hold;
    @(posedge link_clk) disable iff (!lrst_b_r)
      dq_state_r == dq_req && !dma_ack_q |=> dma_request;
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("DMA request dropped before acknowledge"); // RULE6

  property p_req_again;
    @(posedge link_clk) disable iff (!lrst_b_r)
      dq_state_r == dq_idle && start_ok && !dma_ack_q ##1 !dma_ack_q |-> dma_request;
  endproperty
  a_req_again: assert property (p_req_again) else $error("DMA request not raised with data pending"); // RULE4 RULE7

  property p_req_float;
    @(posedge link_clk) disable iff (!lrst_b_r)
      !dev_sel_w |=> !dma_request_oe;
  endproperty
  a_req_float: assert property (p_req_float) else $error("DMA request driven while not selected"); // RULE8

  property p_hstb_latch;
    @(posedge link_clk) disable iff (!lrst_b_r)
      hstb_edge |=> wr_cap_r && wr_cap_data_r == $past(dat_sync_r);
  endproperty
  a_hstb_latch: assert property (p_hstb_latch) else $error("host strobe edge did not latch its word"); // RULE15

  property p_pause_nothing;
    @(posedge link_clk) disable iff (!lrst_b_r)
      udma_on_w && dwr_w && $stable(pin_sync_r[P_RD]) && !(mdma_ok && io_write_strobe_n_rise_w) |=> !wr_cap_r;
  endproperty
  a_pause_nothing: assert property (p_pause_nothing) else $error("word latched without a strobe edge"); // RULE16

  property p_ready_pause;
    @(posedge link_clk) disable iff (!lrst_b_r)
      pin_sync_r[P_RD] [*2] |-> $stable(dev_stb_r);
  endproperty
  a_ready_pause: assert property (p_ready_pause) else $error("data-in word sent while host not ready"); // RULE13

  logic stp_req_seen;
  assign stp_req_seen = stop_r || !dma_ack_q;

  property p_stop_ends;
    @(posedge link_clk) disable iff (!lrst_b_r)
      stop_evt |=> !dma_request ##[1:4] stp_req_seen;
  endproperty
  a_stop_ends: assert property (p_stop_ends) else $error("Ultra burst kept going after stop"); // RULE18

  property p_idle_ignore;
    @(posedge link_clk) disable iff (!lrst_b_r)
      !dma_on_w && dq_state_r == dq_idle |=> dq_state_r == dq_idle && !dma_request;
  endproperty
  a_idle_ignore: assert property (p_idle_ignore) else $error("acknowledge acted on while DMA inactive"); // RULE17

  property p_read_drive;
    @(posedge link_clk) disable iff (!lrst_b_r)
      io_read_sel || mdma_read |=> data_oe;
  endproperty
  a_read_drive: assert property (p_read_drive) else $error("read data not driven during read strobe"); // RULE10 RULE11

  property p_cs_block;
    @(posedge link_clk) disable iff (!lrst_b_r)
      dma_ack_q && !cs_clear_w && !io_write_strobe_n_rise_w |=> !wr_cap_r;
  endproperty
  a_cs_block: assert property (p_cs_block) else $error("DMA word taken with a chip select asserted"); // RULE9

  c_io_read:  cover property (@(posedge link_clk) disable iff (!lrst_b_r) $fell(input_ack_n));
  c_mdma:     cover property (@(posedge link_clk) disable iff (!lrst_b_r) dma_request ##[1:8] !dma_request);
  c_udma_wr:  cover property (@(posedge link_clk) disable iff (!lrst_b_r) hstb_edge ##[1:4] hstb_edge);
  c_udma_stp: cover property (@(posedge link_clk) disable iff (!lrst_b_r) udma_send ##[1:20] stop_evt);

endmodule : chp_host_port

// file: verif/chp_host_model.sv
// Host controller model: strobes, DMA acknowledge and bus data.
// Assumes the bench calls its tasks; pins move 1 ns after link edges.
`timescale 1ns/1ps

module chp_host_model
  import chp_pkg::*;
(
  input  wire logic link_clk,
  output chp_word_t data_in,
  output logic      io_read_strobe_n,
  output logic      io_write_strobe_n,
  output logic      dma_acknowledge_n
);
  initial
  begin
    io_read_strobe_n = 1'b1;
    io_write_strobe_n = 1'b1;
    dma_acknowledge_n = 1'b1;
    data_in = 16'h0000;
  end
  task cyc(input int n);
    repeat (n) @(posedge link_clk);
    #1;
  endtask : cyc
  task strobe(input logic lvl);
    io_read_strobe_n = lvl;
  endtask : strobe
  task ack(input logic a);
    dma_acknowledge_n = !a;
  endtask : ack
  task stop(input logic s);
    io_write_strobe_n = !s;
  endtask : stop
  // One word per strobe edge; bus shows the inverse once released
  task host_data_strobe(input chp_word_t w);
    data_in = w;
    cyc(3);
    io_read_strobe_n = !io_read_strobe_n;
    cyc(4);
    data_in = ~w;
  endtask : host_data_strobe
endmodule : chp_host_model

// file: verif/tb_top.sv
// Bench for the card host port: host model on the pins, core side here.
// Assumes the core sources and the host model are compiled first.
`timescale 1ns/1ps

module tb_top
  import chp_pkg::*;
;
  logic core_clk = 0, link_clk = 0, rst_b = 0, card_select_n, io_addr_hit;
  logic chip_select_0_n, chip_select_1_n, disk_mode_select_n, cfg_io_mode;
  logic dev_selected, dma_active, udma_active, dir_write, xfer_ready;
  logic rd_valid, io_read_strobe_n, io_write_strobe_n, dma_acknowledge_n, data_oe;
  logic input_ack_n, dma_request, dma_request_oe, device_data_strobe, rd_ready, wr_valid;
  logic burst_stopped, direct_disk_mode;
  chp_word_t rd_word, data_in, data_out, wr_word, w;
  chp_word_t exp_q[$];
  int num_errors = 0, checks_done = 0, nwr = 0, nstop = 0, i;

  always #4 core_clk = !core_clk;
  always #62.5 link_clk = !link_clk;

  chp_host_port dut (.*);
  chp_host_model host (.*);

  task chk(input chp_word_t s, input chp_word_t e);
    checks_done++;
    if (s !== e)
    begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task print_verdict();
    $display("checks %0d mismatches %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : print_verdict
  task lk(input int n);
    repeat (n) @(posedge link_clk);
    #1;
  endtask : lk
  task automatic wt(ref logic s, input logic v);
    int n;
    for (n = 0; n < 60 && s !== v; n++)
      lk(1);
    chk(s, v);
    if (n == 60)
      print_verdict();
  endtask : wt
  task reset(input logic strap);
    rst_b = 0;
    disk_mode_select_n = strap;
    lk(5);
    rst_b = 1;
    lk(6);
  endtask : reset
  task give(input chp_word_t v);
    int n;
    rd_word = v;
    rd_valid = 1;
    for (n = 0; n < 60 && rd_ready !== 1'b1; n++)
      @(posedge core_clk) #1;
    if (n == 60)
    begin
      chk(rd_ready, 1'b1);
      print_verdict();
    end
    @(posedge core_clk) #1;
    rd_valid = 0;
  endtask : give

  // Write words are compared in order against the host's queue
  always @(posedge core_clk)
  begin
    if (wr_valid === 1'b1)
    begin
      nwr++;
      chk(wr_word, exp_q.pop_front());
    end
    if (burst_stopped === 1'b1)
      nstop++;
  end

  initial
  begin
    void'($urandom(32'h017B));
    {card_select_n, io_addr_hit, chip_select_0_n, chip_select_1_n, cfg_io_mode} = 5'h1F;
    {dev_selected, dma_active, udma_active, dir_write, xfer_ready, rd_valid} = 6'h04;
    rd_word = 16'h0000;
    reset(1'b1);
    w = 16'($urandom);
    card_select_n = 0;
    io_addr_hit = 0;
    give(w);
    host.strobe(1'b0);
    lk(6);
    chk(input_ack_n, 1'b1);
    chk(data_oe, 1'b0);
    io_addr_hit = 1;
    wt(input_ack_n, 1'b0);
    chk(data_oe, 1'b1);
    chk(data_out, w);
    card_select_n = 1;
    wt(input_ack_n, 1'b1);
    host.strobe(1'b1);
    $display("test 1 done");
    cfg_io_mode = 0;
    card_select_n = 0;
    lk(4);
    host.strobe(1'b0);
    for (i = 0; i < 8; i++)
    begin
      lk(1);
      chk(input_ack_n, 1'b1);
      chk(data_oe, 1'b0);
    end
    host.strobe(1'b1);
    $display("test 2 done");
    reset(1'b0);
    chk(direct_disk_mode, 1'b1);
    chk(dma_request_oe, 1'b0);
    host.ack(1'b1);
    dev_selected = 1;
    xfer_ready = 1;
    udma_active = 1;
    lk(6);
    chk(dma_request, 1'b0);
    chk(dma_request_oe, 1'b1);
    host.ack(1'b0);
    dma_active = 1;
    wt(dma_request, 1'b1);
    host.ack(1'b1);
    repeat (6)
    begin
      w = 16'($urandom);
      exp_q.push_back(w);
      host.host_data_strobe(w);
    end
    lk(4);
    chk(16'(nwr), 16'h0006);
    lk(20);
    chk(16'(nwr), 16'h0006);
    host.stop(1'b1);
    wt(dma_request, 1'b0);
    lk(2);
    chk(16'(nstop), 16'h0001);
    $display("test 3 done");
    udma_active = 0;
    host.stop(1'b0);
    host.ack(1'b0);
    wt(dma_request, 1'b1);
    lk(10);
    chk(dma_request, 1'b1);
    host.ack(1'b1);
    wt(dma_request, 1'b0);
    host.ack(1'b0);
    $display("test 4 done");
    dir_write = 0;
    udma_active = 1;
    chip_select_0_n = 0;
    w = 16'($urandom);
    give(w);
    wt(dma_request, 1'b1);
    host.ack(1'b1);
    host.strobe(1'b0);
    lk(8);
    chk(device_data_strobe, 1'b0);
    chip_select_0_n = 1;
    wt(device_data_strobe, 1'b1);
    chk(data_out, w);
    host.strobe(1'b1);
    w = 16'($urandom);
    give(w);
    lk(8);
    chk(device_data_strobe, 1'b1);
    host.strobe(1'b0);
    wt(device_data_strobe, 1'b0);
    chk(data_out, w);
    $display("test 5 done");
    print_verdict();
  end
endmodule : tb_top
